// ---- idio_pkg.sv ----
// Constants for the instrument digital I/O port bank
package idio_pkg;

  // Bus and port widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam int PORT_W = 8;
  localparam int IN_W = 6;
  localparam int HIGH_OUT_W = 4;
  localparam int IRQ_W = 3;
  localparam int IDX_LSB = 2;
  localparam int RESP_W = 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL_LOW = 10'h321;
  localparam logic [IDX_W-1:0] IDX_INTERNAL = 10'h322;
  localparam logic [IDX_W-1:0] IDX_STATUS_A = 10'h323;
  localparam logic [IDX_W-1:0] IDX_CTRL_HIGH = 10'h325;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h330;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h331;

  // Padding and reset values
  localparam logic [PORT_W-IN_W-1:0] IN_PAD_ONES = 2'h3;
  localparam logic [PORT_W-1:0] PORT_RESET = 8'hFF;
  localparam logic [HIGH_OUT_W-1:0] HIGH_OUT_RESET = 4'hF;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  localparam logic [DATA_W-PORT_W-1:0] UPPER_ZERO = 24'h000000;
  localparam logic [DATA_W-IRQ_W-1:0] IRQ_UPPER_ZERO = 29'h00000000;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;

  // Interrupt status bit positions
  localparam int IRQ_BIT_LOW = 0;
  localparam int IRQ_BIT_HIGH = 1;
  localparam int IRQ_BIT_INT = 2;

  // AXI responses
  localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
  localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- idio_sync.sv ----
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module idio_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1 <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      stage1 <= pin_in;
      sync_out <= stage1;
    end
  end

endmodule

// ---- idio_ports.sv ----
// Digital I/O port bank with AXI4-Lite register access
`timescale 1ns/1ps
module idio_ports
  import idio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [idio_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [idio_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [idio_pkg::RESP_W-1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [idio_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [idio_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [idio_pkg::RESP_W-1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [idio_pkg::IN_W-1:0] ctrl_in_low_n,
  input wire logic [idio_pkg::IN_W-1:0] ctrl_in_high_n,
  input wire logic [idio_pkg::PORT_W-1:0] internal_in,
  output logic [idio_pkg::PORT_W-1:0] ctrl_out_low_n,
  output logic [idio_pkg::HIGH_OUT_W-1:0] ctrl_out_high_n,
  output logic [idio_pkg::PORT_W-1:0] internal_out,
  output logic [idio_pkg::PORT_W-1:0] status_out,
  output logic irq
);

  import idio_pkg::*;

  // Byte address to register index
  function automatic logic [IDX_W-1:0] to_idx(input logic [ADDR_W-1:0] addr);
    to_idx = addr[ADDR_W-1:IDX_LSB];
  endfunction

  // Index belongs to the register map
  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    is_mapped = (idx == IDX_CTRL_LOW) || (idx == IDX_INTERNAL) || (idx == IDX_STATUS_A)
      || (idx == IDX_CTRL_HIGH) || (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK);
  endfunction

  // Synchronised pins
  logic [IN_W-1:0] in_low_s;
  logic [IN_W-1:0] in_high_s;
  logic [PORT_W-1:0] internal_s;
  logic [IN_W-1:0] in_low_prev;
  logic [IN_W-1:0] in_high_prev;
  logic [PORT_W-1:0] internal_prev;

  idio_sync #(.WIDTH(IN_W), .INIT({IN_W{1'b1}})) u_sync_low (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(ctrl_in_low_n),
    .sync_out(in_low_s)
  );

  idio_sync #(.WIDTH(IN_W), .INIT({IN_W{1'b1}})) u_sync_high (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(ctrl_in_high_n),
    .sync_out(in_high_s)
  );

  idio_sync #(.WIDTH(PORT_W), .INIT(PORT_RESET)) u_sync_int (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(internal_in),
    .sync_out(internal_s)
  );

  // Write channel holding registers
  logic aw_held;
  logic w_held;
  logic [IDX_W-1:0] wr_idx;
  logic [PORT_W-1:0] wr_byte;
  logic wr_lane0;

  // Handshakes and decode
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_en = do_write && wr_lane0;
  wire wr_ctrl_low = wr_en && (wr_idx == IDX_CTRL_LOW);
  wire wr_ctrl_high = wr_en && (wr_idx == IDX_CTRL_HIGH);
  wire wr_internal = wr_en && (wr_idx == IDX_INTERNAL);
  wire wr_status = wr_en && (wr_idx == IDX_STATUS_A);
  wire wr_mask = wr_en && (wr_idx == IDX_IRQ_MASK);
  wire [IDX_W-1:0] rd_idx = to_idx(s_axi_araddr);
  wire rd_irq = ar_fire && (rd_idx == IDX_IRQ_STATUS);

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Interrupt status and mask registers
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  // Read word selection
  wire [PORT_W-1:0] rd_ctrl_low = {IN_PAD_ONES, in_low_s};
  wire [PORT_W-1:0] rd_ctrl_high = {IN_PAD_ONES, in_high_s};
  wire [DATA_W-1:0] rd_word =
    (rd_idx == IDX_CTRL_LOW) ? {UPPER_ZERO, rd_ctrl_low} :
    (rd_idx == IDX_CTRL_HIGH) ? {UPPER_ZERO, rd_ctrl_high} :
    (rd_idx == IDX_INTERNAL) ? {UPPER_ZERO, internal_s} :
    (rd_idx == IDX_STATUS_A) ? {UPPER_ZERO, status_out} :
    (rd_idx == IDX_IRQ_STATUS) ? {IRQ_UPPER_ZERO, irq_status} :
    (rd_idx == IDX_IRQ_MASK) ? {IRQ_UPPER_ZERO, irq_mask} : WORD_ZERO;

  // Input change events; set wins over read clear
  logic [IRQ_W-1:0] events;
  assign events[IRQ_BIT_LOW] = |(in_low_s ^ in_low_prev);
  assign events[IRQ_BIT_HIGH] = |(in_high_s ^ in_high_prev);
  assign events[IRQ_BIT_INT] = |(internal_s ^ internal_prev);
  wire [IRQ_W-1:0] next_irq_status = (rd_irq ? IRQ_RESET : irq_status) | events;

  assign irq = |(irq_status & irq_mask);

  // Write address and data capture, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_idx <= '0;
      wr_byte <= '0;
      wr_lane0 <= 1'b0;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_held <= 1'b1;
        wr_idx <= to_idx(s_axi_awaddr);
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (w_fire)
      begin
        w_held <= 1'b1;
        wr_byte <= s_axi_wdata[PORT_W-1:0];
        wr_lane0 <= s_axi_wstrb[0];
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read response; port reads have no side effect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= WORD_ZERO;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Output ports hold until rewritten
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_out_low_n <= PORT_RESET;
      ctrl_out_high_n <= HIGH_OUT_RESET;
      internal_out <= PORT_RESET;
      status_out <= PORT_RESET;
    end
    else
    begin
      if (wr_ctrl_low)
        ctrl_out_low_n <= wr_byte;
      if (wr_ctrl_high)
        ctrl_out_high_n <= wr_byte[HIGH_OUT_W-1:0];
      if (wr_internal)
        internal_out <= wr_byte;
      if (wr_status)
        status_out <= wr_byte;
    end
  end

  // Interrupt status, mask and change history
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_status <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
      in_low_prev <= {IN_W{1'b1}};
      in_high_prev <= {IN_W{1'b1}};
      internal_prev <= PORT_RESET;
    end
    else
    begin
      irq_status <= next_irq_status;
      if (wr_mask)
        irq_mask <= wr_byte[IRQ_W-1:0];
      in_low_prev <= in_low_s;
      in_high_prev <= in_high_s;
      internal_prev <= internal_s;
    end
  end

  // Assertions
  low_in_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && (rd_idx == IDX_CTRL_LOW) |=>
      s_axi_rvalid && (s_axi_rdata == {UPPER_ZERO, IN_PAD_ONES, $past(in_low_s)}))
    else $error("Low control input read mismatch");

  high_in_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && (rd_idx == IDX_CTRL_HIGH) |=>
      s_axi_rvalid && (s_axi_rdata[PORT_W-1:IN_W] == IN_PAD_ONES)
      && (s_axi_rdata[IN_W-1:0] == $past(in_high_s)))
    else $error("High control input read mismatch");

  low_out_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl_low |=> (ctrl_out_low_n == $past(wr_byte)) && s_axi_bvalid)
    else $error("Low control output not written");

  high_out_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl_high |=> ctrl_out_high_n == $past(wr_byte[HIGH_OUT_W-1:0]))
    else $error("High control output not written");

  internal_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && (rd_idx == IDX_INTERNAL) |=>
      (s_axi_rdata == {UPPER_ZERO, $past(internal_s)}) && (s_axi_rresp == RESP_OKAY))
    else $error("Internal input read mismatch");

  internal_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && (wr_idx == IDX_INTERNAL) |=> s_axi_bvalid && (s_axi_bresp == RESP_OKAY))
    else $error("Internal output write refused");

  status_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_status |=> (status_out == $past(wr_byte)) && s_axi_bvalid)
    else $error("Status outputs not written");

  outputs_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !wr_en |=> $stable(ctrl_out_low_n) && $stable(ctrl_out_high_n)
      && $stable(internal_out) && $stable(status_out))
    else $error("Output port changed without a write");

  status_readback_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && (rd_idx == IDX_STATUS_A) |=> s_axi_rdata == {UPPER_ZERO, $past(status_out)})
    else $error("Status readback mismatch");

  read_no_effect_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && (rd_idx != IDX_IRQ_STATUS) && !(|events) |=> $stable(irq_status))
    else $error("Port read changed interrupt status");

  irq_set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_irq && (|events) |=> (irq_status & $past(events)) == $past(events))
    else $error("Change event lost to status read clear");

  mask_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_mask |=> irq_mask == $past(wr_byte[IRQ_W-1:0]))
    else $error("Interrupt mask not written");

  cover_low_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_ctrl_low);
  cover_high_read: cover property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && (rd_idx == IDX_CTRL_HIGH));
  cover_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq ##1 rd_irq);
  cover_bad_addr: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && (s_axi_rresp == RESP_SLVERR));

endmodule

// ---- idio_pins_model.sv ----
// Contact closure model driving the input pins
`timescale 1ns/1ps
module idio_pins_model (
  input wire logic aclk,
  input wire logic slow,
  input wire logic [5:0] lo,
  input wire logic [5:0] hi,
  input wire logic [7:0] sp,
  output logic [5:0] low_n,
  output logic [5:0] high_n,
  output logic [7:0] int_pins
);
  logic [19:0] stage;
  initial
  begin
    stage = 20'hFFFFF;
    {low_n, high_n, int_pins} = 20'hFFFFF;
  end
  // Slow contacts settle one edge later
  always @(posedge aclk)
  begin
    stage <= {lo, hi, sp};
    {low_n, high_n, int_pins} <= slow ? stage : {lo, hi, sp};
  end
endmodule

// ---- instrument_digital_io_ports_tb_top.sv ----
// Self-checking testbench for the digital I/O port bank
`timescale 1ns/1ps
module instrument_digital_io_ports_tb_top;
  import idio_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid, irq, slow;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, ctrl_out_high_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] ctrl_in_low_n, ctrl_in_high_n, p_lo, p_hi;
  logic [7:0] internal_in, ctrl_out_low_n, internal_out, status_out, p_sp;
  logic [2:0] exp_st;
  int failures, checked;
  idio_ports u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1),
    .ctrl_in_low_n, .ctrl_in_high_n, .internal_in, .ctrl_out_low_n, .ctrl_out_high_n,
    .internal_out, .status_out, .irq);
  idio_pins_model u_pins (.aclk, .slow, .lo(p_lo), .hi(p_hi), .sp(p_sp),
    .low_n(ctrl_in_low_n), .high_n(ctrl_in_high_n), .int_pins(internal_in));
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h5A5A5A, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er,
                    input string n);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(n, 32'(e), s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask
  task automatic pins(input logic [5:0] l, input logic [5:0] h, input logic [7:0] s);
    exp_st = exp_st | {s != p_sp, h != p_hi, l != p_lo};
    p_lo <= l;
    p_hi <= h;
    p_sp <= s;
    slow <= 1'($urandom);
    repeat (5) @(posedge aclk);
  endtask
  task automatic irq_is(input logic e);
    @(posedge aclk);
    chk("irq", 32'(e), 32'(irq));
  endtask
  function automatic logic [7:0] pad_in(input logic [5:0] v);
    return {2'h3, v};
  endfunction
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    close_out();
  end
  initial
  begin
    logic [7:0] d, s;
    logic [5:0] l, h;
    logic [7:0] st [5];
    st = '{8'hFE, 8'hFA, 8'hF7, 8'hEF, 8'hDF};
    d = 8'($urandom(32'hEF97A9D4));
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, slow} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {p_lo, p_hi, p_sp, exp_st} = {6'h3F, 6'h3F, 8'hFF, 3'h0};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("reset outs", 32'h0FFFFFFF,
      32'({ctrl_out_low_n, ctrl_out_high_n, internal_out, status_out}));
    for (int i = 0; i < 8; i++)
    begin
      l = (i == 0) ? 6'h00 : 6'($urandom);
      h = (i == 1) ? 6'h00 : 6'($urandom);
      s = 8'($urandom);
      d = (i == 2) ? 8'h00 : 8'($urandom);
      pins(l, h, s);
      rd(12'hC84, pad_in(l), RESP_OKAY, "in low");
      rd(12'hC94, pad_in(h), RESP_OKAY, "in high");
      rd(12'hC88, s, RESP_OKAY, "internal in");
      wr(12'hC84, d, 4'h1, RESP_OKAY);
      chk("out low", 32'(d), 32'(ctrl_out_low_n));
      wr(12'hC94, ~d, 4'h1, RESP_OKAY);
      chk("out high", 32'(~d & 8'h0F), 32'(ctrl_out_high_n));
      wr(12'hC88, d ^ 8'h3C, 4'h1, RESP_OKAY);
      chk("internal out", 32'(d ^ 8'h3C), 32'(internal_out));
      wr(12'hC8C, d, 4'h1, RESP_OKAY);
      chk("status", 32'(d), 32'(status_out));
      rd(12'hC8C, d, RESP_OKAY, "status back");
    end
    wr(12'hC84, ~d, 4'h0, RESP_OKAY);
    wr(12'hD00, ~d, 4'h1, RESP_SLVERR);
    rd(12'hD00, 8'h00, RESP_SLVERR, "unmapped");
    rd(12'hC84, pad_in(l), RESP_OKAY, "in low again");
    chk("held out", {24'h0, d}, 32'(ctrl_out_low_n));
    foreach (st[k])
    begin
      wr(12'hC8C, st[k], 4'h1, RESP_OKAY);
      chk("status flags", 32'(st[k]), 32'(status_out));
    end
    rd(12'hCC0, 8'(exp_st), RESP_OKAY, "events");
    exp_st = 3'h0;
    irq_is(1'b0);
    wr(12'hCC4, 8'h07, 4'h1, RESP_OKAY);
    rd(12'hCC4, 8'h07, RESP_OKAY, "mask");
    pins(~l, h, s);
    irq_is(1'b1);
    rd(12'hCC0, 8'h01, RESP_OKAY, "low event");
    irq_is(1'b0);
    wr(12'hCC4, 8'h00, 4'h1, RESP_OKAY);
    pins(~l, ~h, s);
    irq_is(1'b0);
    rd(12'hCC0, 8'h02, RESP_OKAY, "masked event");
    // Mid-run reset returns every output port and the mask to its reset value
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("rerun outs", 32'h0FFFFFFF,
      32'({ctrl_out_low_n, ctrl_out_high_n, internal_out, status_out}));
    chk("irq after reset", 32'h0, 32'(irq));
    rd(12'hCC4, 8'h00, RESP_OKAY, "mask reset");
    close_out();
  end
endmodule
